// ===== hw/ssrp_pkg.sv
// shared constants and carrier types of the serial slave register port
package ssrp_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CORE_CLK_PERIOD_NS = 40;
  // least spacings asked of the far side and longest reply times of this port, in ns
  localparam int unsigned SEL_TO_FIRST_SCK_NS = 2 * CORE_CLK_PERIOD_NS;
  localparam int unsigned LAST_SCK_TO_DESEL_NS = 2 * CORE_CLK_PERIOD_NS;
  localparam int unsigned SEL_TO_MISO_VALID_NS = 4 * CORE_CLK_PERIOD_NS;
  localparam int unsigned DESEL_TO_MISO_HIZ_NS = 4 * CORE_CLK_PERIOD_NS;
  // least times round up, longest times round down
  localparam int unsigned SEL_TO_FIRST_SCK_CYC =
    (SEL_TO_FIRST_SCK_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int unsigned LAST_SCK_TO_DESEL_CYC =
    (LAST_SCK_TO_DESEL_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int unsigned SEL_TO_MISO_VALID_CYC = SEL_TO_MISO_VALID_NS / CORE_CLK_PERIOD_NS;
  localparam int unsigned DESEL_TO_MISO_HIZ_CYC = DESEL_TO_MISO_HIZ_NS / CORE_CLK_PERIOD_NS;

  // ==========================================================
  // serial mode, fixed: clock idles low, sample on first edge
  localparam logic CLOCK_POLARITY_SELECT = 1'h0;
  localparam logic CLOCK_PHASE_SELECT = 1'h0;

  // ==========================================================
  // widths and reset values
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned BIT_CNT_W = 3;
  localparam int unsigned FRAME_CNT_W = 16;
  localparam logic [BYTE_W-1:0] SHIFT_RST = 8'h00;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST = 3'h0;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = 3'h7;
  localparam logic [FRAME_CNT_W-1:0] FRAME_CNT_RST = 16'h0000;
  localparam logic MISO_IDLE = 1'h0;

  // ==========================================================
  // carrier types
  typedef struct packed {
    logic sck;
    logic sel_n;
    logic mosi;
  } ssrp_pins_t;

  typedef struct packed {
    logic [BYTE_W-1:0] data;
    logic valid;
  } ssrp_rx_t;

  typedef struct packed {
    logic start;
    logic done;
    logic partial;
  } ssrp_frame_ev_t;

  typedef enum logic [0:0] {
    SSRP_IDLE = 1'b0,
    SSRP_ACTIVE = 1'b1
  } ssrp_state_t;

endpackage : ssrp_pkg

// ===== hw/ssrp_sync.sv
// two flip-flop synchroniser, one per bit
`timescale 1ns/100ps
module ssrp_sync #(
  parameter int unsigned WIDTH = 3
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] rst_val,
  output logic [WIDTH-1:0] sync_out
);
  import ssrp_pkg::*;

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // ==========================================================
  // per-bit stages; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge core_clk) begin
        if (rst) begin
          meta_r[i] <= rst_val[i];
          sync_r[i] <= rst_val[i];
        end else begin
          meta_r[i] <= async_in[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_r;

endmodule : ssrp_sync

// ===== hw/ssrp_port.sv
// serial slave register port: mode zero byte engine sampled on the core clock
// ==========================================================
// What this block does
// - bytes come in on the data-in line, most significant bit first
// - reply bits go out on the data-out line, most significant bit first
// - data-out is released to high impedance while select is high
// - serial clock edges are ignored while select is high
// - select falling starts a transfer, select rising ends it
// - write-only synchronous transfers accepted up to core rate over four
// - data-out valid within four core periods after select falls
// - data-out released within four core periods after select rises
`timescale 1ns/100ps
module ssrp_port (
  input wire logic core_clk,
  input wire logic rst,
  input wire ssrp_pkg::ssrp_pins_t pins_in,
  output logic miso_out,
  output logic miso_oe_n,
  input wire logic [ssrp_pkg::BYTE_W-1:0] tx_data,
  output logic tx_take,
  output ssrp_pkg::ssrp_rx_t rx_out,
  output ssrp_pkg::ssrp_frame_ev_t frame_ev,
  output logic frame_active,
  output logic [ssrp_pkg::FRAME_CNT_W-1:0] frame_bytes
);
  import ssrp_pkg::*;

  // ==========================================================
  // pin synchronisation
  // master timing is ten core periods per bit, so two stages plus one
  // edge register still leave room before the next edge
  // write-only bursts at a quarter of the core rate still hold each
  // level two periods, so every edge is seen once; reply bits lag there
  ssrp_pins_t pins_s;
  ssrp_pins_t pins_rst_val;
  ssrp_pins_t pins_d_r;

  assign pins_rst_val = '{sck: 1'b0, sel_n: 1'b1, mosi: 1'b0};

  ssrp_sync #(
    .WIDTH(3)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(pins_in),
    .rst_val(pins_rst_val),
    .sync_out(pins_s)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pins_d_r <= '{sck: 1'b0, sel_n: 1'b1, mosi: 1'b0};
    end else begin
      pins_d_r <= pins_s;
    end
  end

  // ==========================================================
  // edge decode
  // reset values match the idle pins, so no false edge follows reset
  wire sel_fall = pins_d_r.sel_n & ~pins_s.sel_n;
  wire sel_rise = ~pins_d_r.sel_n & pins_s.sel_n;
  wire selected = ~pins_s.sel_n;
  wire sck_rise_raw = ~pins_d_r.sck & pins_s.sck;
  wire sck_fall_raw = pins_d_r.sck & ~pins_s.sck;

  ssrp_state_t state_r;
  ssrp_state_t state_nxt;

  // clock edges count only inside a frame that has already started
  wire in_frame = (state_r == SSRP_ACTIVE) & selected;
  wire sck_rise = sck_rise_raw & in_frame;
  wire sck_fall = sck_fall_raw & in_frame;

  // ==========================================================
  // frame state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SSRP_IDLE: begin
        if (sel_fall) begin
          state_nxt = SSRP_ACTIVE;
        end
      end
      SSRP_ACTIVE: begin
        if (!selected) begin
          state_nxt = SSRP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= SSRP_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // bit counter and receive shifter
  logic [BIT_CNT_W-1:0] bit_cnt_r;
  logic [BIT_CNT_W-1:0] bit_cnt_nxt;
  logic [BYTE_W-1:0] rx_shift_r;
  logic [BYTE_W-1:0] rx_shift_nxt;
  logic [BYTE_W-1:0] tx_shift_r;
  logic [BYTE_W-1:0] tx_shift_nxt;
  logic byte_end_r;

  wire byte_done = sck_rise & (bit_cnt_r == BIT_CNT_LAST);
  wire [BYTE_W-1:0] rx_assembled = {rx_shift_r[BYTE_W-2:0], pins_s.mosi};

  // deselect clears the bit counter and shifters so each frame opens on a byte boundary
  assign bit_cnt_nxt = !in_frame ? BIT_CNT_RST :
                       sck_rise ? bit_cnt_r + 3'h1 : bit_cnt_r;
  assign rx_shift_nxt = !in_frame ? SHIFT_RST :
                        sck_rise ? rx_assembled : rx_shift_r;

  // next reply byte is loaded at frame start and on the falling edge
  // that closes each byte; other falling edges shift left
  wire tx_load = sel_fall | (sck_fall & byte_end_r);
  assign tx_shift_nxt = tx_load ? tx_data :
                        !in_frame ? SHIFT_RST :
                        sck_fall ? {tx_shift_r[BYTE_W-2:0], 1'b0} : tx_shift_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bit_cnt_r <= BIT_CNT_RST;
      rx_shift_r <= SHIFT_RST;
      tx_shift_r <= SHIFT_RST;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      rx_shift_r <= rx_shift_nxt;
      tx_shift_r <= tx_shift_nxt;
    end
  end

  // remembers that the last rising edge completed a byte
  always_ff @(posedge core_clk) begin
    if (rst) begin
      byte_end_r <= 1'b0;
    end else if (!in_frame) begin
      byte_end_r <= 1'b0;
    end else if (byte_done) begin
      byte_end_r <= 1'b1;
    end else if (sck_fall) begin
      byte_end_r <= 1'b0;
    end
  end

  // ==========================================================
  // data-out pin
  // registered straight from the shifter head: select to valid is
  // two sync stages plus one register, three core periods
  logic miso_r;
  logic miso_oe_n_r;

  wire miso_nxt = tx_load ? tx_data[BYTE_W-1] : tx_shift_nxt[BYTE_W-1];
  wire drive_nxt = (state_nxt == SSRP_ACTIVE);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      miso_r <= MISO_IDLE;
      miso_oe_n_r <= 1'b1;
    end else begin
      miso_r <= drive_nxt ? miso_nxt : MISO_IDLE;
      miso_oe_n_r <= ~drive_nxt;
    end
  end

  assign miso_out = miso_r;
  assign miso_oe_n = miso_oe_n_r;

  // ==========================================================
  // user side: received bytes, reply load strobe, frame events
  ssrp_rx_t rx_r;
  ssrp_frame_ev_t ev_r;
  logic [FRAME_CNT_W-1:0] frame_bytes_r;

  // an opened frame ends on the deselect edge; a stray rise while idle
  // reports nothing
  wire frame_end = (state_r == SSRP_ACTIVE) & sel_rise;
  // a frame closed with bits still pending reports a partial byte
  wire partial_nxt = frame_end & (bit_cnt_r != BIT_CNT_RST);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_r <= '{data: SHIFT_RST, valid: 1'b0};
      ev_r <= '{start: 1'b0, done: 1'b0, partial: 1'b0};
      frame_bytes_r <= FRAME_CNT_RST;
    end else begin
      rx_r.valid <= byte_done;
      if (byte_done) begin
        rx_r.data <= rx_assembled;
      end
      ev_r.start <= sel_fall;
      ev_r.done <= frame_end;
      ev_r.partial <= partial_nxt;
      if (sel_fall) begin
        frame_bytes_r <= FRAME_CNT_RST;
      end else if (byte_done) begin
        frame_bytes_r <= frame_bytes_r + 16'h0001;
      end
    end
  end

  // tx_data is taken in the cycle tx_take is high
  // no stall: user logic must hold a reply byte ready whenever a load may fall
  assign tx_take = tx_load;
  assign rx_out = rx_r;
  assign frame_ev = ev_r;
  assign frame_active = (state_r == SSRP_ACTIVE);
  assign frame_bytes = frame_bytes_r;

endmodule : ssrp_port

// ===== verif/ssrp_port_monitor.sv
// checker for the serial slave register port
`timescale 1ns/100ps
module ssrp_port_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire ssrp_pkg::ssrp_pins_t pins_in,
  input wire logic miso_out,
  input wire logic miso_oe_n,
  input wire logic tx_take,
  input wire ssrp_pkg::ssrp_rx_t rx_out,
  input wire ssrp_pkg::ssrp_frame_ev_t frame_ev,
  input wire logic frame_active,
  input wire logic [ssrp_pkg::FRAME_CNT_W-1:0] frame_bytes
);
  import ssrp_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ====
  // select edges on the raw pin
  sequence s_fall; $fell(pins_in.sel_n); endsequence
  sequence s_rise; $rose(pins_in.sel_n); endsequence
  sequence s_idle; pins_in.sel_n [*5]; endsequence
  a_oe_on: assert property (s_fall |-> ##[1:4] !miso_oe_n) else $error("oe late");
  a_oe_off: assert property (s_rise |-> ##[1:4] miso_oe_n) else $error("hiz late");
  a_hiz_idle: assert property (s_idle |-> miso_oe_n) else $error("driving idle");
  a_no_rx: assert property (s_idle |-> !rx_out.valid) else $error("rx idle");
  a_byte_cnt: assert property (rx_out.valid |-> frame_active
    && frame_bytes == $past(frame_bytes) + 16'h0001) else $error("count");
  a_start_ev: assert property (s_fall |-> ##[2:4] frame_ev.start) else $error("start");
  a_done_ev: assert property (s_rise |-> ##[2:4] frame_ev.done) else $error("done");
  a_start_load: assert property (frame_ev.start |-> $past(tx_take)
    && frame_bytes == 16'h0000) else $error("load");
  a_idle_low: assert property (miso_oe_n |-> miso_out == MISO_IDLE)
    else $error("miso idle");
  a_cnt_hold: assert property (s_idle |-> $stable(frame_bytes))
    else $error("count idle");
endmodule : ssrp_port_monitor
bind ssrp_port ssrp_port_monitor ssrp_port_monitor_i (.core_clk(core_clk), .rst(rst),
  .pins_in(pins_in), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .tx_take(tx_take),
  .rx_out(rx_out), .frame_ev(frame_ev), .frame_active(frame_active),
  .frame_bytes(frame_bytes));

// ===== verif/ssrp_master_model.sv
// mode zero serial master model, bit period and pin skew set per frame
`timescale 1ns/100ps
module ssrp_master_model (
  input wire logic core_clk,
  input wire logic go,
  input wire logic wiggle,
  input wire logic [4:0] nbits,
  input wire logic [3:0] half,
  input wire logic [4:0] skew,
  input wire logic [15:0] wr_data,
  input wire logic miso,
  output ssrp_pkg::ssrp_pins_t pins,
  output logic [15:0] rd_data,
  output logic busy
);
  import ssrp_pkg::*;
  initial begin
    pins = 3'b010;
    rd_data = 16'h0000;
    busy = 1'b0;
  end
  // clock idles low, sample on rising edge
  // a nonzero skew moves every pin change of a frame off the core edge, as an unsynchronised master; idle sck and mosi toggles stay on it
  always @(posedge core_clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      pins.sel_n <= #(skew) 1'b0;
      repeat (3) @(posedge core_clk);
      for (int i = 0; i < nbits; i++) begin
        pins.mosi <= #(skew) wr_data[15-i];
        repeat (half) @(posedge core_clk);
        pins.sck <= #(skew) 1'b1;
        rd_data <= {rd_data[14:0], miso};
        repeat (half) @(posedge core_clk);
        pins.sck <= #(skew) 1'b0;
      end
      repeat (3) @(posedge core_clk);
      pins.sel_n <= #(skew) 1'b1;
      busy <= 1'b0;
    end else if (wiggle) begin
      pins.sck <= ~pins.sck;
    end
    // released data line never holds its last bit
    if (pins.sel_n) pins.mosi <= ~pins.mosi;
  end
endmodule : ssrp_master_model

// ===== verif/tb.sv
// self-checking bench for the serial slave register port
`timescale 1ns/100ps
module tb;
  import ssrp_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic wiggle = 1'b0;
  logic [4:0] nbits = 5'h08;
  logic [3:0] half = 4'h4;
  logic [4:0] skew = 5'h00;
  logic [15:0] wr_data = 16'h0000;
  logic [7:0] tx_data = 8'h3C;
  ssrp_pins_t pins;
  ssrp_rx_t rx_out;
  ssrp_frame_ev_t frame_ev;
  logic miso_out, miso_oe_n, tx_take, frame_active, busy;
  logic [15:0] frame_bytes, rd_data;
  logic [15:0] rx_log = 16'h0000;
  logic [7:0] v;
  int partials = 0;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  wire miso_wire = miso_oe_n ? 1'bz : miso_out;
  ssrp_port ssrp_port_i (.core_clk(core_clk), .rst(rst), .pins_in(pins),
    .miso_out(miso_out), .miso_oe_n(miso_oe_n), .tx_data(tx_data), .tx_take(tx_take),
    .rx_out(rx_out), .frame_ev(frame_ev), .frame_active(frame_active),
    .frame_bytes(frame_bytes));
  ssrp_master_model ssrp_master_model_i (.core_clk(core_clk), .go(go), .wiggle(wiggle),
    .nbits(nbits), .half(half), .skew(skew), .wr_data(wr_data), .miso(miso_wire),
    .pins(pins), .rd_data(rd_data),
    .busy(busy));
  initial forever #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (tx_take) tx_data <= tx_data + 8'h11;
    if (rx_out.valid) rx_log <= {rx_log[7:0], rx_out.data};
    if (frame_ev.partial) partials <= partials + 1;
    // ====
    // hang guard, run needs well under 2000 cycles
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic frame(logic [4:0] n, logic [15:0] d, logic [3:0] h, logic [4:0] s);
    int t;
    t = 0;
    v = tx_data;
    nbits <= n;
    wr_data <= d;
    half <= h;
    skew <= s;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    while (!busy && t < 10) begin @(posedge core_clk); t++; end
    while (busy && t < 500) begin @(posedge core_clk); t++; end
    repeat (6) @(posedge core_clk);
  endtask : frame
  task automatic t_idle_clk();
    wiggle <= 1'b1;
    repeat (40) @(posedge core_clk);
    wiggle <= 1'b0;
    check("idle rx", rx_log, 16'h0000);
    check("idle act", {15'h0000, frame_active}, 16'h0000);
    check("idle miso", {15'h0000, miso_wire}, {15'h0000, 1'hZ});
  endtask : t_idle_clk
  task automatic t_partial();
    frame(5'h05, 16'hF800, 4'h4, 5'h00);
    check("partial", partials[15:0], 16'h0001);
    check("part rx", rx_log, 16'h0000);
  endtask : t_partial
  task automatic t_one_byte();
    frame(5'h08, 16'hA500, 4'h5, 5'h00);
    check("rx one", rx_log, 16'h00A5);
    check("tx one", rd_data[7:0], v);
    check("bytes one", frame_bytes, 16'h0001);
  endtask : t_one_byte
  task automatic t_two_bytes();
    frame(5'h10, 16'h5A81, 4'h6, 5'h0D);
    check("rx two", rx_log, 16'h5A81);
    check("tx two", rd_data, {v, v + 8'h11});
    check("bytes two", frame_bytes, 16'h0002);
  endtask : t_two_bytes
  task automatic t_write_fast();
    frame(5'h10, 16'hC33C, 4'h2, 5'h00);
    check("rx fast", rx_log, 16'hC33C);
    check("bytes fast", frame_bytes, 16'h0002);
  endtask : t_write_fast
  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    check("oe idle", {15'h0000, miso_oe_n}, 16'h0001);
    t_idle_clk();
    t_partial();
    t_one_byte();
    t_two_bytes();
    t_write_fast();
    results();
  end
endmodule : tb
